// *** dv/disu_asserts.sv ***
// Purpose: concurrent checks on the interrupt and status unit ports
// Assumes: one clock domain, async active-high reset
// Notes:   g_on mirrors the global enable from the instruction pulses
`timescale 1ns/1ps
module disu_asserts
	import disu_pkg::*;
(
	input wire logic                         clk,             // clock
	input wire logic                         reset,           // reset
	input wire logic                         instr_boundary,  // boundary
	input wire logic                         global_int_on,   // enable pulse
	input wire logic                         global_int_off,  // disable pulse
	input wire logic                         pwrdn_req,       // powerdown
	input wire logic                         reg_wr,          // bus write
	input wire logic                         alu_valid,       // alu op
	input wire logic [2:0]                   alu_op,          // alu class
	input wire logic [3:0]                   alu_znvc,        // alu flags
	input wire logic                         alu_quotient,    // quotient
	input wire logic                         mac_valid,       // mac op
	input wire logic                         mac_saturate,    // saturate op
	input wire logic                         mac_ovf,         // mac overflow
	input wire logic                         exp_valid,       // exponent op
	input wire logic                         exp_sign,        // shifter sign
	input wire logic                         int_take,        // entry cycle
	input wire logic [3:0]                   int_vector,      // level
	input wire logic [disu_pkg::ARITH_W-1:0] arith_flags_out  // flags
);
	logic g_on;

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			g_on <= 1'b1;
		else if (global_int_off)
			g_on <= 1'b0;
		else if (global_int_on)
			g_on <= 1'b1;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	// same-edge enable or disable pulses are left out: they change the enable only after the edge
	sequence s_pd_ready;
		// powerdown counts only after its two sync stages
		instr_boundary && $past(pwrdn_req, 2) && g_on && !int_take
			&& !global_int_off && !global_int_on;
	endsequence
	sequence s_pd_taken;
		int_take && int_vector == VEC_PWRDN;
	endsequence

	a_take_at_boundary: assert property (int_take |-> $past(instr_boundary))
		else $error("entry without instruction boundary");
	a_take_gated: assert property (int_take |-> $past(g_on))
		else $error("entry while globally disabled");
	a_pd_first: assert property (s_pd_ready |=> s_pd_taken)
		else $error("powerdown not served first");
	a_take_single: assert property (int_take |=> !int_take)
		else $error("entry cycle longer than one");
	a_alu_latch: assert property (alu_valid && !reg_wr &&
		(alu_op == DISU_ALU_PLAIN || alu_op == DISU_ALU_ABS)
		|=> arith_flags_out[3:0] == $past(alu_znvc))
		else $error("alu flags not latched");
	a_pass_carry: assert property (alu_valid && !reg_wr && alu_op == DISU_ALU_PASS
		|=> arith_flags_out[3:0] == {1'b0, $past(alu_znvc[2:0])})
		else $error("pass flags wrong");
	a_divide_keep: assert property (alu_valid && !reg_wr &&
		(alu_op == DISU_ALU_DIVIDE_FIRST_STEP || alu_op == DISU_ALU_DIVIDE_NEXT_STEP)
		|=> $stable(arith_flags_out[3:0]) && arith_flags_out[AF_QUO] == $past(alu_quotient))
		else $error("divide step flags wrong");
	a_mac_flag: assert property (mac_valid && !mac_saturate && !reg_wr
		|=> arith_flags_out[AF_MAC] == $past(mac_ovf))
		else $error("mac overflow not latched");
	a_exp_sign: assert property (exp_valid && !reg_wr
		|=> arith_flags_out[AF_SHS] == $past(exp_sign))
		else $error("shift sign not latched");
endmodule

bind disu_core disu_asserts disu_asserts_inst (
	.clk, .reset, .instr_boundary, .global_int_on, .global_int_off, .pwrdn_req,
	.reg_wr, .alu_valid, .alu_op, .alu_znvc, .alu_quotient, .mac_valid,
	.mac_saturate, .mac_ovf, .exp_valid, .exp_sign, .int_take, .int_vector,
	.arith_flags_out
);

// *** dv/disu_core_model.sv ***
// Purpose: behavioural instruction core and host-port request source
// Assumes: one boundary every stall+1 cycles stands for wait states
// Notes:   host requests are levels held until either host routine is entered, which drops both
`timescale 1ns/1ps
module disu_core_model (
	input  wire logic       clk,            // clock
	input  wire logic       reset,          // reset
	input  wire logic [1:0] stall,          // extra cycles per instruction
	input  wire logic [1:0] hp_raise,       // start host requests
	input  wire logic       int_take,       // entry cycle
	input  wire logic [3:0] int_vector,     // serviced level
	output logic            instr_boundary, // instruction complete
	output logic [1:0]      host_port_req   // host request levels
);
	logic [1:0] wait_cnt;

	assign instr_boundary = (wait_cnt == 2'h0);

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			wait_cnt <= 2'h0;
		else if (instr_boundary)
			wait_cnt <= stall;
		else
			wait_cnt <= wait_cnt - 2'h1;
	end

	// dropping at entry, not at return, so the level is never served twice
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			host_port_req <= 2'h0;
		else if (int_take && (int_vector == 4'h5 || int_vector == 4'h6))
			host_port_req <= 2'h0;
		else
			host_port_req <= host_port_req | hp_raise;
	end
endmodule

// *** dv/dsp_interrupt_status_unit_tb.sv ***
// Purpose: self-checking bench of the interrupt and status unit
// Assumes: the core model makes boundaries and host requests, the bench drives the rest
// Notes:   default depths, so the count stack holds four entries
`timescale 1ns/1ps
module dsp_interrupt_status_unit_tb;
	import disu_pkg::*;
	typedef struct packed {
		logic [2:0] op;
		logic [3:0] znvc;
		logic       q;
		logic       m;
		logic       s;
		logic [7:0] want;
	} disu_row_s;
	logic        clk = 0, reset = 1, ib, rd_en = 0, wr_en = 0, pwrdn_req = 0, take;
	logic        gon = 0, goff = 0, rfi = 0, a_v = 0, m_v = 0, sat = 0, qb = 0;
	logic [2:0]  ext_n = 3'h7, sel = 3'h0, op = 3'h0;
	logic [7:0]  ev = 8'h00, af;
	logic [1:0]  hp, hp_raise = 2'h0, stall = 2'h0;
	logic [6:0]  mo;
	logic [3:0]  znvc = 4'h0, push = 4'h0, pop = 4'h0, vec;
	logic [15:0] wd = 16'h0, rdat, d;
	int          error_cnt = 0, samples_checked = 0, lat, cyc = 0;
	disu_row_s   rows [5] = '{'{DISU_ALU_PLAIN, 4'hf, 1'b1, 1'b1, 1'b0, 8'hcf},
		'{DISU_ALU_DIVIDE_FIRST_STEP, 4'h0, 1'b1, 1'b1, 1'b1, 8'hef},
		'{DISU_ALU_PASS, 4'hb, 1'b0, 1'b0, 1'b0, 8'he3},
		'{DISU_ALU_ABS, 4'h0, 1'b1, 1'b1, 1'b0, 8'hf0},
		'{DISU_ALU_DIVIDE_NEXT_STEP, 4'h5, 1'b0, 1'b1, 1'b0, 8'h10}};

	disu_core disu_core_inst (.clk, .reset, .ext_req_n(ext_n), .int_event(ev),
		.host_port_req(hp), .pwrdn_req, .instr_boundary(ib), .global_int_on(gon),
		.global_int_off(goff), .return_from_isr(rfi), .reg_sel(sel), .reg_wr(wr_en),
		.reg_rd(rd_en), .dmd_wdata(wd), .alu_valid(a_v), .alu_op(op), .alu_znvc(znvc),
		.alu_abs_sign(qb), .alu_quotient(qb), .mac_valid(m_v), .mac_saturate(sat),
		.mac_ovf(qb), .exp_valid(m_v), .exp_sign(qb), .stk_push(push), .stk_pop(pop),
		.dmd_rdata(rdat), .int_take(take), .int_vector(vec), .arith_flags_out(af),
		.mode_flags_out(mo), .status_restore());
	disu_core_model disu_core_model_inst (.clk, .reset, .stall, .hp_raise,
		.int_take(take), .int_vector(vec), .instr_boundary(ib), .host_port_req(hp));

	always #2.5 clk = ~clk;

	task automatic tally_and_finish;
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// hang guard, well above the fewer than two hundred cycles the sequence needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic bus(input logic w, input logic [2:0] s, input logic [15:0] v);
		wr_en = w;
		rd_en = !w;
		sel = s;
		wd = v;
		tk(1);
		wr_en = 0;
		rd_en = 0;
		d = rdat;
		tk(1);
	endtask
	task automatic wt(input logic [3:0] v, input int lim);
		lat = 0;
		while (take !== 1'b1 && lat < lim) begin
			tk(1);
			lat++;
		end
		chk({11'h0, take, vec}, {12'h1, v});
	endtask
	task automatic quiet(input int n);
		repeat (n) begin
			tk(1);
			chk({15'h0, take}, 16'h0);
		end
	endtask
	task automatic ev_pulse(input logic [7:0] b);
		ev = b;
		tk(1);
		ev = 0;
	endtask
	// routine runs first, so a level dropped at entry has left the sync
	task automatic ret;
		tk(2);
		rfi = 1;
		tk(1);
		rfi = 0;
		tk(1);
	endtask
	task automatic stk(input logic po);
		repeat (5) begin
			push = po ? 4'h0 : 4'h2;
			pop = po ? 4'h2 : 4'h0;
			tk(1);
			push = 0;
			pop = 0;
			tk(1);
		end
		bus(0, 3'h1, 0);
	endtask

	initial begin
		tk(2);
		reset = 0;
		bus(0, 3'h1, 0);
		chk(d, 16'h0055);
		bus(0, 3'h4, 0);
		chk(d, 16'h0000);
		bus(0, 3'h5, 0);
		chk(d, 16'h0000);
		bus(1, 3'h2, 16'h0055);
		bus(0, 3'h2, 0);
		chk(d, 16'h0055);
		chk({9'h0, mo}, 16'h0055);
		foreach (rows[i]) begin
			a_v = 1;
			op = rows[i].op;
			znvc = rows[i].znvc;
			qb = rows[i].q;
			m_v = rows[i].m;
			sat = rows[i].s;
			tk(1);
			chk({8'h0, af}, {8'h0, rows[i].want});
		end
		a_v = 0;
		m_v = 0;
		bus(1, 3'h4, 16'h0001);
		bus(1, 3'h5, 16'h0100);
		wt(0, 10);
		chk(16'(lat), 16'h0001);
		bus(0, 3'h4, 0);
		chk(d, 16'h0000);
		ret();
		bus(0, 3'h4, 0);
		chk(d, 16'h0001);
		quiet(8);
		bus(1, 3'h3, 16'h0010);
		bus(1, 3'h4, 16'h00ff);
		ev_pulse(8'h08);
		wt(3, 10);
		chk({15'h0, lat >= 3}, 16'h0001);
		bus(0, 3'h4, 0);
		chk(d, 16'h00f0);
		ret();
		bus(1, 3'h4, 16'h0000);
		ev_pulse(8'h10);
		bus(1, 3'h5, 16'h6000);
		bus(1, 3'h5, 16'h0010);
		bus(1, 3'h4, 16'h00ff);
		quiet(10);
		goff = 1;
		tk(1);
		goff = 0;
		ev_pulse(8'h10);
		pwrdn_req = 1;
		quiet(10);
		gon = 1;
		tk(1);
		gon = 0;
		pwrdn_req = 0;
		wt(4'h8, 10);
		ret();
		wt(4, 10);
		ret();
		bus(1, 3'h4, 16'h0000);
		ev_pulse(8'h08);
		tk(5);
		bus(1, 3'h4, 16'h0008);
		wt(3, 4);
		chk(16'(lat), 16'h0000);
		ret();
		stall = 2'h2;
		bus(1, 3'h4, 16'h0020);
		hp_raise = 2'h1;
		tk(1);
		hp_raise = 2'h0;
		wt(5, 20);
		ret();
		bus(1, 3'h3, 16'h0011);
		bus(1, 3'h4, 16'h0002);
		ext_n = 3'h6;
		wt(1, 20);
		ret();
		ext_n = 3'h7;
		stk(0);
		chk({14'h0, d[3:2]}, 16'h0002);
		bus(1, 3'h1, 16'h0000);
		bus(0, 3'h1, 0);
		chk({14'h0, d[3:2]}, 16'h0002);
		stk(1);
		chk({14'h0, d[3:2]}, 16'h0003);
		bus(1, 3'h0, 16'h005a);
		bus(0, 3'h0, 0);
		chk(d, 16'h005a);
		chk({8'h0, af}, 16'h005a);
		tally_and_finish();
	end
endmodule

// *** hw/disu_core.sv ***
// Purpose: interrupt controller, status registers and stack flags of a dsp sequencer
// Assumes: core pulses instr_boundary when an instruction fully completes
// Notes:   int_take marks the nop cycle; the core fetches the vector then
`timescale 1ns/1ps
// Functional notes
// - nesting on: entry clears serviced and lower mask bits, keeps higher ones
// - global off blocks every interrupt, powerdown too, regardless of mask
// - global enable is on after reset; global on re-allows unmasked interrupts
// - force/clear acts one cycle after the write; timer may act at once
// - forced request serviced once unless masked; external only when edge-type
// - timer, serial and converter requests are latched, maskable, forceable
// - pending edge request clears by clear bit or on entering its routine
// - host port requests have no force or clear bits
// - request to first routine instruction takes at least three cycles
// - interrupts taken only at instruction boundaries after full completion
// - last latency cycle is a nop with vector fetch and pc push
// - masked pending request starts one cycle after the unmasking instruction
// - optional fast timer reaches its routine after one fetch cycle
// - status and mode read/write; stack flags read-only; force/clear write-only
// - entry pushes arithmetic, mode and mask; return pops them
// - arithmetic flags are 8 bits, positive sense
// - each arithmetic flag updates only on its own class of operation
// - flags latch at end of the generating cycle, visible next cycle
// - direct loads leave flags; pass sets zero and negative, clears carry
// - stack flags hold one empty bit per stack, pops at least pushes
// - overflow sets beyond depth; newest pushes discarded, older kept
// - overflow stays until reset even when empty returns
// - nesting off: entry clears the whole mask
// - mask resets to zero; 1 enables, 0 masks
// - edge external request latched on falling pin edge, held while masked
module disu_core
	import disu_pkg::*;
#(
	parameter bit TIMER_FAST = 1'b0,
	parameter int PC_DEPTH   = 16,
	parameter int CNT_DEPTH  = 4,
	parameter int STAT_DEPTH = 10,
	parameter int LOOP_DEPTH = 4
) (
	input  wire logic                   clk,             // 200 MHz clock
	input  wire logic                   reset,           // async reset
	input  wire logic [2:0]             ext_req_n,       // external pins, active low
	input  wire logic [disu_pkg::N_INT-1:0] int_event,   // internal edge events
	input  wire logic [1:0]             host_port_req,   // host read/write levels
	input  wire logic                   pwrdn_req,       // powerdown request
	input  wire logic                   instr_boundary,  // instruction completes
	input  wire logic                   global_int_on,   // enable instruction
	input  wire logic                   global_int_off,  // disable instruction
	input  wire logic                   return_from_isr, // return instruction
	input  wire logic [2:0]             reg_sel,         // register select code
	input  wire logic                   reg_wr,          // bus write strobe
	input  wire logic                   reg_rd,          // bus read strobe
	input  wire logic [disu_pkg::DW-1:0] dmd_wdata,      // bus write data
	input  wire logic                   alu_valid,       // alu op this cycle
	input  wire logic [2:0]             alu_op,          // alu op class
	input  wire logic [3:0]             alu_znvc,        // zero neg ovf carry
	input  wire logic                   alu_abs_sign,    // abs input sign
	input  wire logic                   alu_quotient,    // divide quotient bit
	input  wire logic                   mac_valid,       // mac op this cycle
	input  wire logic                   mac_saturate,    // mac op is saturate
	input  wire logic                   mac_ovf,         // mac overflow
	input  wire logic                   exp_valid,       // exponent detect op
	input  wire logic                   exp_sign,        // shifter sign
	input  wire logic [3:0]             stk_push,        // core pushes per stack
	input  wire logic [3:0]             stk_pop,         // core pops per stack
	output logic [disu_pkg::DW-1:0]     dmd_rdata,       // bus read data
	output logic                        int_take,        // nop cycle, vector fetch
	output logic [3:0]                  int_vector,      // serviced level
	output logic [disu_pkg::ARITH_W-1:0] arith_flags_out, // flags to conditions
	output logic [disu_pkg::MODE_W-1:0] mode_flags_out,  // operating mode
	output logic                        status_restore   // popped frame applied
);
	import disu_pkg::*;

	localparam int SAW = $clog2(STAT_DEPTH);
	localparam int DEPTHS [N_STACK] = '{PC_DEPTH, CNT_DEPTH, STAT_DEPTH, LOOP_DEPTH};

	logic [ARITH_W-1:0] arithmetic_flags;
	logic [MODE_W-1:0]  mode_flags;
	logic [CFG_W-1:0]   interrupt_config;
	logic [CFG_W-1:0]   cfg_active;
	logic [N_INT-1:0]   interrupt_enable_mask;
	logic [N_INT-1:0]   pend;
	logic [N_INT-1:0]   force_q;
	logic [N_INT-1:0]   clear_q;
	logic               global_on;
	logic [N_STACK*2-1:0] stack_flags;
	logic [LVL_W-1:0]   level [N_STACK];
	logic               pop_wait;

	logic [2:0]         ext_sync;
	logic [2:0]         ext_sync_n;
	logic [2:0]         ext_prev_n;
	logic [N_INT-1:0]   ev_sync;
	logic [1:0]         hp_sync;
	logic               pd_sync;
	logic [N_INT-1:0]   ev_use;
	logic [N_INT-1:0]   is_edge;
	logic [N_INT-1:0]   pin_fall;
	logic [N_INT-1:0]   pin_level;
	logic [N_INT-1:0]   force_now;
	logic [N_INT-1:0]   clear_now;
	logic [N_INT-1:0]   req;
	logic [N_INT-1:0]   active;
	logic [N_INT-1:0]   serviced;
	logic [2:0]         top_lvl;
	logic               take_any;
	logic               take_pd;
	logic [N_INT-1:0]   next_mask;
	logic [SSTK_W-1:0]  stat_rdata;
	logic               wr_force;
	logic [3:0]         push_v;
	logic [3:0]         pop_v;

	disu_sync #(.W(3)) u_sync_ext (
		.clk   (clk),
		.reset (reset),
		.d     (~ext_req_n),
		.q     (ext_sync)
	);
	// synchronised active high so reset leaves the pins idle, no false fall
	assign ext_sync_n = ~ext_sync;

	disu_sync #(.W(N_INT + 3)) u_sync_int (
		.clk   (clk),
		.reset (reset),
		.d     ({int_event, host_port_req, pwrdn_req}),
		.q     ({ev_sync, hp_sync, pd_sync})
	);

	// timer bypasses synchronisation in the fast variant
	always_comb begin
		ev_use = ev_sync;
		if (TIMER_FAST) begin
			ev_use[INT_TIMER] = int_event[INT_TIMER];
		end
	end

	// config changes reach the interrupt logic one cycle late
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cfg_active <= CFG_RST;
			ext_prev_n <= 3'h7;
		end else begin
			cfg_active <= interrupt_config;
			ext_prev_n <= ext_sync_n;
		end
	end

	always_comb begin
		pin_fall  = '0;
		pin_level = '0;
		is_edge   = ~(HOST_BITS | EXT_BITS);
		pin_fall[INT_IRQ0]  = ext_prev_n[0] & ~ext_sync_n[0];
		pin_fall[INT_IRQ1]  = ext_prev_n[1] & ~ext_sync_n[1];
		pin_fall[INT_IRQ2]  = ext_prev_n[2] & ~ext_sync_n[2];
		pin_level[INT_IRQ0] = ~ext_sync_n[0];
		pin_level[INT_IRQ1] = ~ext_sync_n[1];
		pin_level[INT_IRQ2] = ~ext_sync_n[2];
		pin_level[INT_HP_RD] = hp_sync[0];
		pin_level[INT_HP_WR] = hp_sync[1];
		is_edge[INT_IRQ0] = cfg_active[0];
		is_edge[INT_IRQ1] = cfg_active[1];
		is_edge[INT_IRQ2] = cfg_active[2];
	end

	// force/clear: latched one cycle, host bits never present
	assign wr_force = reg_wr && (reg_sel == DISU_REG_FORCE);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			force_q <= '0;
			clear_q <= '0;
		end else begin
			force_q <= '0;
			clear_q <= '0;
			if (wr_force) begin
				force_q <= dmd_wdata[FC_FORCE_LO +: N_INT] & ~HOST_BITS;
				clear_q <= dmd_wdata[FC_CLEAR_LO +: N_INT] & ~HOST_BITS;
			end
		end
	end

	always_comb begin
		force_now = force_q;
		clear_now = clear_q;
		if (TIMER_FAST && wr_force) begin
			force_now[INT_TIMER] = dmd_wdata[FC_FORCE_LO + INT_TIMER];
			clear_now[INT_TIMER] = dmd_wdata[FC_CLEAR_LO + INT_TIMER];
		end
		if (TIMER_FAST) begin
			force_now[INT_TIMER] = force_now[INT_TIMER] | force_q[INT_TIMER];
		end
	end

	// pending latches: a new edge beats a clear in the same cycle
	genvar gi;
	generate
		for (gi = 0; gi < N_INT; gi++) begin : g_pend
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					pend[gi] <= 1'b0;
				end else if (is_edge[gi] && (ev_use[gi] || pin_fall[gi] || force_now[gi])) begin
					pend[gi] <= 1'b1;
				end else if (!is_edge[gi] || clear_now[gi] || serviced[gi]) begin
					pend[gi] <= 1'b0;
				end
			end
			assign req[gi] = is_edge[gi] ? pend[gi] : pin_level[gi];
		end
	endgenerate

	// masked pending requests wait; the boundary after an unmask takes them
	assign active = req & interrupt_enable_mask;

	always_comb begin
		top_lvl = 3'h0;
		for (int i = 0; i < N_INT; i++) begin
			if (active[i]) begin
				top_lvl = 3'(i);
			end
		end
	end

	assign take_pd  = instr_boundary && global_on && pd_sync && !int_take;
	assign take_any = instr_boundary && global_on && (|active) && !int_take;

	always_comb begin
		serviced = '0;
		if (take_any && !take_pd) begin
			serviced[top_lvl] = 1'b1;
		end
	end

	always_comb begin
		if (!cfg_active[CFG_NEST]) begin
			next_mask = '0;
		end else if (take_pd) begin
			next_mask = '0;
		end else begin
			next_mask = interrupt_enable_mask & ~((N_INT'(2) << top_lvl) - N_INT'(1));
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			int_take   <= 1'b0;
			int_vector <= 4'h0;
		end else begin
			int_take <= take_any || take_pd;
			if (take_pd) begin
				int_vector <= VEC_PWRDN;
			end else if (take_any) begin
				int_vector <= {1'b0, top_lvl};
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			global_on <= 1'b1;
		end else if (global_int_off) begin
			global_on <= 1'b0;
		end else if (global_int_on) begin
			global_on <= 1'b1;
		end
	end

	// stack depth counters: level keeps counting past depth so pops re-empty it
	assign push_v = stk_push | {1'b0, take_any || take_pd, 1'b0, take_any || take_pd};
	assign pop_v  = stk_pop | {1'b0, return_from_isr, 2'b00};

	generate
		for (gi = 0; gi < N_STACK; gi++) begin : g_stk
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					level[gi]            <= '0;
					stack_flags[2*gi+1]  <= 1'b0;
				end else begin
					if (push_v[gi] && !pop_v[gi] && level[gi] != '1) begin
						level[gi] <= level[gi] + LVL_W'(1);
					end else if (pop_v[gi] && !push_v[gi] && level[gi] != '0) begin
						level[gi] <= level[gi] - LVL_W'(1);
					end
					if (push_v[gi] && !pop_v[gi] && level[gi] >= LVL_W'(DEPTHS[gi])) begin
						stack_flags[2*gi+1] <= 1'b1;
					end
				end
			end
			assign stack_flags[2*gi] = (level[gi] == '0);
		end
	endgenerate

	// writes beyond depth are dropped so older frames survive
	disu_stack_mem #(.W(SSTK_W), .D(STAT_DEPTH), .AW(SAW)) u_stat_stack (
		.clk   (clk),
		.reset (reset),
		.we    ((take_any || take_pd) && level[STK_STAT] < LVL_W'(STAT_DEPTH)),
		.waddr (level[STK_STAT][SAW-1:0]),
		.wdata ({arithmetic_flags, mode_flags, interrupt_enable_mask}),
		.raddr (SAW'(level[STK_STAT] - LVL_W'(1))),
		.rdata (stat_rdata)
	);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pop_wait       <= 1'b0;
			status_restore <= 1'b0;
		end else begin
			pop_wait       <= return_from_isr && level[STK_STAT] != '0
				&& level[STK_STAT] <= LVL_W'(STAT_DEPTH);
			status_restore <= pop_wait;
		end
	end

	// mask and config registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			interrupt_enable_mask <= MASK_RST;
			interrupt_config      <= CFG_RST;
		end else begin
			if (take_any || take_pd) begin
				interrupt_enable_mask <= next_mask;
			end else if (pop_wait) begin
				interrupt_enable_mask <= stat_rdata[N_INT-1:0];
			end else if (reg_wr && reg_sel == DISU_REG_MASK) begin
				interrupt_enable_mask <= dmd_wdata[N_INT-1:0];
			end
			if (reg_wr && reg_sel == DISU_REG_CFG) begin
				interrupt_config <= dmd_wdata[CFG_W-1:0];
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode_flags <= MODE_RST;
		end else if (pop_wait) begin
			mode_flags <= stat_rdata[N_INT +: MODE_W];
		end else if (reg_wr && reg_sel == DISU_REG_MODE) begin
			mode_flags <= dmd_wdata[MODE_W-1:0];
		end
	end

	// arithmetic flags latch at the clock edge closing the generating cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			arithmetic_flags <= ARITH_RST;
		end else if (pop_wait) begin
			arithmetic_flags <= stat_rdata[N_INT+MODE_W +: ARITH_W];
		end else if (reg_wr && reg_sel == DISU_REG_ARITH) begin
			arithmetic_flags <= dmd_wdata[ARITH_W-1:0];
		end else begin
			if (alu_valid && alu_op != DISU_ALU_DIVIDE_FIRST_STEP && alu_op != DISU_ALU_DIVIDE_NEXT_STEP) begin
				arithmetic_flags[AF_ZERO]  <= alu_znvc[0];
				arithmetic_flags[AF_NEG]   <= alu_znvc[1];
				arithmetic_flags[AF_OVF]   <= alu_znvc[2];
				arithmetic_flags[AF_CARRY] <= (alu_op == DISU_ALU_PASS) ? 1'b0 : alu_znvc[3];
			end
			if (alu_valid && alu_op == DISU_ALU_ABS) begin
				arithmetic_flags[AF_ABS] <= alu_abs_sign;
			end
			if (alu_valid && (alu_op == DISU_ALU_DIVIDE_FIRST_STEP || alu_op == DISU_ALU_DIVIDE_NEXT_STEP)) begin
				arithmetic_flags[AF_QUO] <= alu_quotient;
			end
			if (mac_valid && !mac_saturate) begin
				arithmetic_flags[AF_MAC] <= mac_ovf;
			end
			if (exp_valid) begin
				arithmetic_flags[AF_SHS] <= exp_sign;
			end
		end
	end

	assign arith_flags_out = arithmetic_flags;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode_flags_out <= MODE_RST;
		end else begin
			mode_flags_out <= (pop_wait) ? stat_rdata[N_INT +: MODE_W] :
				(reg_wr && reg_sel == DISU_REG_MODE) ? dmd_wdata[MODE_W-1:0] : mode_flags;
		end
	end

	// register read port; the force/clear register reads as zero
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dmd_rdata <= '0;
		end else if (reg_rd) begin
			unique case (reg_sel)
				DISU_REG_ARITH: dmd_rdata <= DW'(arithmetic_flags);
				DISU_REG_STACK: dmd_rdata <= DW'(stack_flags);
				DISU_REG_MODE:  dmd_rdata <= DW'(mode_flags);
				DISU_REG_CFG:   dmd_rdata <= DW'(interrupt_config);
				DISU_REG_MASK:  dmd_rdata <= DW'(interrupt_enable_mask);
				default:        dmd_rdata <= '0;
			endcase
		end
	end
endmodule

// *** hw/disu_pkg.sv ***
// Purpose: shared constants of the interrupt and status unit
// Assumes: single clock, asynchronous active-high reset
// Notes:   interrupt bit index equals priority level, 0 lowest
package disu_pkg;
	localparam int N_INT      = 8;
	localparam int DW         = 16;
	localparam int ARITH_W    = 8;
	localparam int MODE_W     = 7;
	localparam int CFG_W      = 5;
	localparam int N_STACK    = 4;
	localparam int LVL_W      = 6;
	localparam int SSTK_W     = ARITH_W + MODE_W + N_INT;

	// register select codes on the data memory data bus
	typedef enum logic [2:0] {
		DISU_REG_ARITH = 3'h0,
		DISU_REG_STACK = 3'h1,
		DISU_REG_MODE  = 3'h2,
		DISU_REG_CFG   = 3'h3,
		DISU_REG_MASK  = 3'h4,
		DISU_REG_FORCE = 3'h5
	} disu_reg_e;

	// alu operation classes reported by the core
	typedef enum logic [2:0] {
		DISU_ALU_PLAIN = 3'h0,
		DISU_ALU_DIVIDE_FIRST_STEP  = 3'h1,
		DISU_ALU_DIVIDE_NEXT_STEP  = 3'h2,
		DISU_ALU_ABS   = 3'h3,
		DISU_ALU_PASS  = 3'h4
	} disu_alu_e;

	// interrupt bit positions
	localparam int INT_TIMER  = 0;
	localparam int INT_IRQ0   = 1;
	localparam int INT_IRQ1   = 2;
	localparam int INT_HP_RD  = 5;
	localparam int INT_HP_WR  = 6;
	localparam int INT_IRQ2   = 7;
	localparam logic [N_INT-1:0] HOST_BITS   = 8'h60;
	localparam logic [N_INT-1:0] EXT_BITS    = 8'h86;
	localparam logic [3:0]       VEC_PWRDN   = 4'h8;

	// arithmetic flag positions
	localparam int AF_ZERO = 0;
	localparam int AF_NEG  = 1;
	localparam int AF_OVF  = 2;
	localparam int AF_CARRY = 3;
	localparam int AF_ABS  = 4;
	localparam int AF_QUO  = 5;
	localparam int AF_MAC  = 6;
	localparam int AF_SHS  = 7;

	// config fields and force/clear halves
	localparam int CFG_NEST   = 4;
	localparam int FC_FORCE_LO = 8;
	localparam int FC_CLEAR_LO = 0;

	// stack indices inside the stack flag register (two bits each)
	localparam int STK_PC     = 0;
	localparam int STK_CNT    = 1;
	localparam int STK_STAT   = 2;
	localparam int STK_LOOP   = 3;

	localparam logic [ARITH_W-1:0] ARITH_RST = 8'h00;
	localparam logic [MODE_W-1:0]  MODE_RST  = 7'h00;
	localparam logic [CFG_W-1:0]   CFG_RST   = 5'h00;
	localparam logic [N_INT-1:0]   MASK_RST  = 8'h00;
	localparam int SYNC_STAGES = 2;
endpackage

// *** hw/disu_stack_mem.sv ***
// Purpose: status stack storage with registered read data
// Assumes: caller keeps writes inside depth
// Notes:   no reset on the array, only on read data
`timescale 1ns/1ps
module disu_stack_mem #(
	parameter int W = 23,
	parameter int D = 4,
	parameter int AW = 2
) (
	input  wire logic          clk,   // processor clock
	input  wire logic          reset, // async reset
	input  wire logic          we,    // write strobe
	input  wire logic [AW-1:0] waddr, // write slot
	input  wire logic [W-1:0]  wdata, // saved frame
	input  wire logic [AW-1:0] raddr, // read slot
	output logic      [W-1:0]  rdata  // registered frame
);
	logic [W-1:0] mem [D];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata <= '0;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule

// *** hw/disu_sync.sv ***
// Purpose: two-stage synchroniser for request inputs
// Assumes: inputs may change at any clock edge
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module disu_sync #(
	parameter int W = 8
) (
	input  wire logic         clk,   // processor clock
	input  wire logic         reset, // async reset
	input  wire logic [W-1:0] d,     // raw request
	output logic      [W-1:0] q      // synchronised request
);
	logic [W-1:0] stage1;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			stage1 <= '0;
			q      <= '0;
		end else begin
			stage1 <= d;
			q      <= stage1;
		end
	end
endmodule
